/* File: verilog/rsc_consts.vh */
// Constants for the reset source control block
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// ==========================================================
// Register byte offsets
`define RSC_OFS_CAUSE   8'h00
`define RSC_OFS_KEY     8'h04
`define RSC_OFS_PINCFG  8'h08
`define RSC_OFS_PORT1   8'h0c
`define RSC_OFS_TRIM    8'h10
// ==========================================================
// Field positions in reset_cause_status
`define RSC_B_VD        0
`define RSC_B_WDT       1
`define RSC_B_SYSCLK    2
`define RSC_B_TRIMRST   3
`define RSC_B_TRIMFLT   4
`define RSC_B_CLRREQ    7
// Field positions in the pin and port registers
`define RSC_B_RESET_PIN_DISABLE    0
`define RSC_B_PORTMODE  1
`define RSC_B_PINLVL    2
`define RSC_B_PULLUP    0
`define RSC_B_DIR       1
// ==========================================================
// Key codes and reset values
`define RSC_KEY_CLEAR   8'h71
`define RSC_KEY_PIN     8'hb2
`define RSC_CAUSE_RST   8'h00
`define RSC_TRIM_RST    8'h00
// AXI responses
`define RSC_RESP_OKAY   2'b00
`define RSC_RESP_SLVERR 2'b10
// ==========================================================
// Timing: pin low time in ns, clock period in ns
`define RSC_PIN_LOW_NS  5000
`define RSC_CLK_NS      5
`define RSC_PIN_LOW_CYC ((`RSC_PIN_LOW_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
// Warm-up length in cycles
`define RSC_WARMUP_CYC  1024
`endif

/* File: verilog/rsc_top.v */
// Reset source control: reset gathering, warm-up, cause status, pin mode
//
// Behaviour
// RULE1: Pin low five microseconds forces device reset
// RULE2: Pin release starts warm-up, then CPU runs
// RULE3: Voltage detection raises internal reset
// RULE4: Watchdog overflow raises internal reset
// RULE5: Deadlocking oscillator setting raises clock reset
// RULE6: Warm-up loads and latches trimming bits
// RULE7: Corrupted latched trimming bits raise reset
// RULE8: Abnormal loaded trimming bits set fault flag
// RULE9: Software reloads trimming via internal reset
// RULE10: Cause register shows source of internal reset
// RULE11: Cause register cleared only by pin/power-on
// RULE12: Clear request plus key 0x71 clears causes
// RULE13: Clear request bit returns to zero afterwards
// RULE14: Software writes keys only in gear 00
// RULE15: Port use needs pin high through warm-up
// RULE16: Disable bit plus key 0xb2 frees pin
// RULE17: Cleared disable bit plus key restores reset
// RULE18: Software switches pin mode only while high
// RULE19: Power-on and pin reset are ORed
// RULE20: Internal sources share one reset, set cause
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`include "rsc_consts.vh"
`default_nettype none

module rsc_top (
  input  wire        clock,          // 200 MHz system clock
  input  wire        sys_rst,        // Power-on reset, sync, high
  input  wire        clk_en,         // Freezes all state when low
  input  wire        reset_pin_n,    // External reset pin level
  input  wire        volt_detect,    // Voltage detector reached level
  input  wire        wdt_overflow,   // Watchdog overflow event
  input  wire [1:0]  osc_enable,     // Oscillator enables {low, high}
  input  wire        sysclk_sel,     // 1 selects the low oscillator
  input  wire [7:0]  trim_nv_data,   // Trimming bits from storage
  input  wire        trim_nv_par,    // Odd parity bit from storage
  output wire        cpu_reset,      // Reset to CPU and peripherals
  output wire        trim_rd,        // Storage read during warm-up
  output reg  [7:0]  trim_value_q,   // Latched trimming bits
  output reg         port_mode_q,    // Pin freed as a port
  output reg         pullup_q,       // Port bit pull-up
  output reg         direction_q,    // Port bit direction
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ========================================================
  // Sequencer states
  localparam [1:0] ST_RST  = 2'd0;  // Reset held
  localparam [1:0] ST_WARM = 2'd1;  // Warm-up running
  localparam [1:0] ST_RUN  = 2'd2;  // CPU running

  // Integer forms, cut to the counter widths on purpose
  localparam integer PIN_LOW_INT = `RSC_PIN_LOW_CYC;
  localparam integer WARM_INT    = `RSC_WARMUP_CYC - 1;
  localparam [9:0]  PIN_LOW_MAX = PIN_LOW_INT[9:0];
  localparam [10:0] WARM_LAST   = WARM_INT[10:0];

  // True for offsets that hold a register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `RSC_OFS_CAUSE) || (a == `RSC_OFS_KEY) ||
               (a == `RSC_OFS_PINCFG) || (a == `RSC_OFS_PORT1) ||
               (a == `RSC_OFS_TRIM);
    end
  endfunction

  reg  [1:0]  state_q;        // Sequencer state
  reg  [10:0] warm_cnt_q;     // Warm-up cycle count
  reg         pin_s1_q;       // Pin synchroniser stages
  reg         pin_s2_q;
  reg         pin_s3_q;
  reg         pin_q;          // Filtered pin level
  reg  [9:0]  low_cnt_q;      // Pin low duration
  reg  [7:0]  cause_q;        // reset_cause_status
  reg         reset_pin_disable_q;       // reset_pin_disable
  reg  [7:0]  trim_shadow_q;  // Duplicate copy for upset check
  reg         aw_full_q;      // Write address held
  reg  [7:0]  aw_addr_q;
  reg         w_full_q;       // Write data held
  reg  [7:0]  w_data_q;
  reg         w_lane0_q;      // Low byte lane enabled

  // ========================================================
  // Reset source evaluation
  wire pin_en     = ~port_mode_q;
  wire pin_low    = pin_en & ~pin_q;
  // Outside run any low holds reset; in run it must last 5 us
  wire pin_rst    = pin_low &
                    ((state_q != ST_RUN) || (low_cnt_q == PIN_LOW_MAX)); // [RULE1] [RULE19]
  wire running    = (state_q == ST_RUN);
  wire ev_vd      = running & volt_detect;                            // [RULE3]
  wire ev_wdt     = running & wdt_overflow;                           // [RULE4]
  // Selected oscillator switched off leaves the CPU without clock
  wire ev_sysclk  = running &
                    (sysclk_sel ? ~osc_enable[1] : ~osc_enable[0]);   // [RULE5]
  wire ev_trim    = running & (trim_value_q != trim_shadow_q);        // [RULE7]
  wire any_int    = ev_vd | ev_wdt | ev_sysclk | ev_trim;             // [RULE20]
  wire warm_first = (state_q == ST_WARM) && (warm_cnt_q == 11'd0);
  // Odd parity over data and parity bit means good bits
  wire trim_bad   = ~(^{trim_nv_data, trim_nv_par});

  assign cpu_reset = ~running;                                        // [RULE2]
  assign trim_rd   = (state_q == ST_WARM);

  // ========================================================
  // Bus handshakes
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_wr  = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_ok  = do_wr & mapped(aw_addr_q) & w_lane0_q;
  wire wr_key = wr_ok & (aw_addr_q == `RSC_OFS_KEY);
  wire do_rd  = s_axi_arvalid & ~s_axi_rvalid;
  wire key_clr = wr_key & (w_data_q == `RSC_KEY_CLEAR) &
                 cause_q[`RSC_B_CLRREQ];                              // [RULE12]
  // Pin mode change only with pulled-up input configuration
  wire key_pin = wr_key & (w_data_q == `RSC_KEY_PIN) &
                 pullup_q & ~direction_q;                             // [RULE16] [RULE17]

  // ========================================================
  // Pin synchroniser and filter
  always @(posedge clock) begin
    if (sys_rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
      pin_q    <= 1'b1;
    end else if (clk_en) begin
      pin_s1_q <= reset_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      // Level accepted only when two stages agree
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
    end
  end

  // ========================================================
  // Pin low duration counter
  always @(posedge clock) begin
    if (sys_rst) begin
      low_cnt_q <= 10'd0;
    end else if (clk_en) begin
      if (!pin_low) begin
        low_cnt_q <= 10'd0;
      end else if (low_cnt_q != PIN_LOW_MAX) begin
        low_cnt_q <= low_cnt_q + 10'd1;                               // [RULE1]
      end
    end
  end

  // ========================================================
  // Reset sequencer
  always @(posedge clock) begin
    if (sys_rst) begin
      state_q    <= ST_RST;
      warm_cnt_q <= 11'd0;
    end else if (clk_en) begin
      case (state_q)
        ST_RST: begin
          // Leave when the later of pin and power-on releases
          if (!pin_rst) begin
            state_q    <= ST_WARM;                                    // [RULE2] [RULE19]
            warm_cnt_q <= 11'd0;
          end
        end
        ST_WARM: begin
          if (pin_rst) begin
            state_q <= ST_RST;
          end else if (warm_cnt_q == WARM_LAST) begin
            state_q <= ST_RUN;                                        // [RULE2]
          end else begin
            warm_cnt_q <= warm_cnt_q + 11'd1;
          end
        end
        ST_RUN: begin
          // Every source funnels into the one reset
          if (pin_rst || any_int) begin
            state_q <= ST_RST;                                        // [RULE20]
          end
        end
        default: begin
          state_q <= ST_RST;
        end
      endcase
    end
  end

  // ========================================================
  // Trimming bits latch, loaded on first warm-up cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      trim_value_q  <= `RSC_TRIM_RST;
      trim_shadow_q <= `RSC_TRIM_RST;
    end else if (clk_en && warm_first) begin
      trim_value_q  <= trim_nv_data;                                  // [RULE6]
      trim_shadow_q <= trim_nv_data;
    end
  end

  // ========================================================
  // Cause register; events win over a key clear in the same cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      cause_q <= `RSC_CAUSE_RST;                                      // [RULE11]
    end else if (clk_en) begin
      if (pin_rst) begin
        cause_q <= `RSC_CAUSE_RST;                                    // [RULE11]
      end else begin
        if (key_clr) begin
          cause_q <= 8'h00;                                           // [RULE12] [RULE13]
        end else if (wr_ok && aw_addr_q == `RSC_OFS_CAUSE) begin
          cause_q[`RSC_B_CLRREQ] <= w_data_q[`RSC_B_CLRREQ];
        end
        if (ev_vd) begin
          cause_q[`RSC_B_VD] <= 1'b1;                                 // [RULE10]
        end
        if (ev_wdt) begin
          cause_q[`RSC_B_WDT] <= 1'b1;                                // [RULE10]
        end
        if (ev_sysclk) begin
          cause_q[`RSC_B_SYSCLK] <= 1'b1;                             // [RULE10]
        end
        if (ev_trim) begin
          cause_q[`RSC_B_TRIMRST] <= 1'b1;                            // [RULE10]
        end
        if (warm_first && trim_bad) begin
          cause_q[`RSC_B_TRIMFLT] <= 1'b1;                            // [RULE8]
        end
      end
    end
  end

  // ========================================================
  // Pin and port configuration; restored by any reset
  always @(posedge clock) begin
    if (sys_rst) begin
      reset_pin_disable_q    <= 1'b0;
      port_mode_q <= 1'b0;
      pullup_q    <= 1'b0;
      direction_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == ST_RST) begin
        reset_pin_disable_q    <= 1'b0;
        port_mode_q <= 1'b0;
        pullup_q    <= 1'b0;
        direction_q <= 1'b0;
      end else begin
        if (wr_ok && aw_addr_q == `RSC_OFS_PINCFG) begin
          reset_pin_disable_q <= w_data_q[`RSC_B_RESET_PIN_DISABLE];
        end
        if (wr_ok && aw_addr_q == `RSC_OFS_PORT1) begin
          pullup_q    <= w_data_q[`RSC_B_PULLUP];
          direction_q <= w_data_q[`RSC_B_DIR];
        end
        // The disable bit acts only through the key
        if (key_pin) begin
          port_mode_q <= reset_pin_disable_q;                                    // [RULE16] [RULE17]
        end
      end
    end
  end

  // ========================================================
  // Write channel capture and response
  always @(posedge clock) begin
    if (sys_rst) begin
      aw_full_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_full_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped offsets answer with a slave error
        s_axi_bresp  <= mapped(aw_addr_q) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================
  // Read channel; key register reads as zero
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RSC_RESP_OKAY;
    end else if (clk_en) begin
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
        case (s_axi_araddr)
          `RSC_OFS_CAUSE: begin
            s_axi_rdata <= {24'h000000, cause_q};                     // [RULE10]
          end
          `RSC_OFS_PINCFG: begin
            s_axi_rdata <= {29'h00000000, pin_q, port_mode_q, reset_pin_disable_q};
          end
          `RSC_OFS_PORT1: begin
            s_axi_rdata <= {30'h00000000, direction_q, pullup_q};
          end
          `RSC_OFS_TRIM: begin
            s_axi_rdata <= {24'h000000, trim_value_q};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rsc_top

`default_nettype wire

/* File: tb/rsc_monitor.sv */
// Port checker for the reset source control block
`default_nettype none
module rsc_monitor (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       reset_pin_n,
  input wire logic       volt_detect,
  input wire logic       wdt_overflow,
  input wire logic [1:0] osc_enable,
  input wire logic       sysclk_sel,
  input wire logic [7:0] trim_nv_data,
  input wire logic       cpu_reset,
  input wire logic       trim_rd,
  input wire logic [7:0] trim_value_q,
  input wire logic       port_mode_q,
  input wire logic       pullup_q,
  input wire logic       direction_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Helper counters
  logic [10:0] warm_q;  // Warm-up cycles so far
  logic [10:0] low_q;   // Pin-low cycles so far
  logic        run;     // Core running, events sampled
  assign run = !cpu_reset && clk_en;
  // Counters clear on reset; pin runs never exceed the width
  always_ff @(posedge clock) begin
    warm_q <= (sys_rst || !trim_rd) ? 11'h000 : warm_q + 11'h001;
    low_q  <= (sys_rst || reset_pin_n) ? 11'h000 : low_q + 11'h001;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Port relations
  chk_warm_len: assert property ($fell(trim_rd) |-> warm_q == 11'h400)
    else $error("warm-up length wrong");
  chk_run_after: assert property ($fell(cpu_reset) |-> $past(trim_rd))
    else $error("core started without warm-up");
  chk_volt_reset: assert property (run && volt_detect |=> cpu_reset)
    else $error("voltage event gave no reset");
  chk_wdt_reset: assert property (run && wdt_overflow |=> cpu_reset)
    else $error("watchdog event gave no reset");
  chk_clk_dead: assert property (run && !osc_enable[sysclk_sel] |=> cpu_reset)
    else $error("clock deadlock gave no reset");
  chk_trim_load: assert property ($fell(trim_rd) |-> trim_value_q == $past(trim_nv_data))
    else $error("trimming bits not latched");
  chk_pin_reset: assert property (low_q == 11'h3fc && !port_mode_q |-> cpu_reset)
    else $error("long pin low gave no reset");
  chk_port_key: assert property ($rose(port_mode_q) |-> $past(pullup_q) && !$past(direction_q))
    else $error("port freed without pull-up input");
endmodule // rsc_monitor
bind rsc_top rsc_monitor u_mon (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
  .volt_detect(volt_detect), .wdt_overflow(wdt_overflow), .osc_enable(osc_enable),
  .sysclk_sel(sysclk_sel), .trim_nv_data(trim_nv_data), .cpu_reset(cpu_reset),
  .trim_rd(trim_rd), .trim_value_q(trim_value_q), .port_mode_q(port_mode_q),
  .pullup_q(pullup_q), .direction_q(direction_q)
);
`default_nettype wire

/* File: tb/rsc_ext.sv */
// Model of the board reset driver and the trimming storage
`default_nettype none
module rsc_ext (
  input  wire logic       clock,
  input  wire logic       trim_rd,
  input  wire logic       pin_go,
  input  wire logic       bad_par,
  input  wire logic [7:0] new_trim,
  output logic            reset_pin_n,
  output logic [7:0]      trim_nv_data,
  output logic            trim_nv_par
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  logic [10:0] hold_q;  // Pin-low cycles left
  initial begin
    hold_q = 11'h000;
    trim_nv_data = 8'h00;
    trim_nv_par = 1'b1;
  end
  // Pull-up keeps the pin high unless asked, so warm-up is never cut
  assign reset_pin_n = (hold_q == 11'h000);
  always @(posedge clock) begin
    if (pin_go)
      hold_q <= 11'h4b0;  // 1200 cycles, well over the 5 us
    else if (hold_q != 11'h000)
      hold_q <= hold_q - 11'h001;
    // Contents move only outside warm-up, so the load sees stable bits
    if (!trim_rd) begin
      trim_nv_data <= new_trim;
      trim_nv_par  <= ~^new_trim ^ bad_par;  // Odd parity, broken on request
    end
  end
endmodule // rsc_ext
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the reset source control block
`include "rsc_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  logic        clock, sys_rst, volt_detect, wdt_overflow, sysclk_sel, pin_go, bad_par, clk_en;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, cpu_reset, trim_rd, port_mode_q, reset_pin_n, trim_nv_par;
  logic [1:0]  osc_enable, bresp, rresp;
  logic [7:0]  awaddr, araddr, new_trim, tv, cause, trim_nv_data;
  logic [31:0] wdata, rdata;
  logic [33:0] rd_q[$];  // Expected {resp, data} of reads
  logic [1:0]  wr_q[$];  // Expected write responses
  int          err_count, n_compared, cyc;
  rsc_top uut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
    .volt_detect(volt_detect), .wdt_overflow(wdt_overflow), .osc_enable(osc_enable),
    .sysclk_sel(sysclk_sel), .trim_nv_data(trim_nv_data), .trim_nv_par(trim_nv_par),
    .cpu_reset(cpu_reset), .trim_rd(trim_rd), .trim_value_q(), .port_mode_q(port_mode_q),
    .pullup_q(), .direction_q(), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  rsc_ext u_ext (
    .clock(clock), .trim_rd(trim_rd), .pin_go(pin_go), .bad_par(bad_par),
    .new_trim(new_trim), .reset_pin_n(reset_pin_n), .trim_nv_data(trim_nv_data),
    .trim_nv_par(trim_nv_par)
  );
  // ==========================================
  // Clock, timeout and result checking
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: bus %h, expected %h", $time, got, exp);
    end
  endtask
  // Arguments are copied at the call, so callers wait for mid-cycle first
  task automatic cmp_lvl(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: level %b, expected %b", $time, got, exp);
    end
  endtask
  // Watcher takes the oldest note at each completed response
  always @(posedge clock) begin
    cyc++;
    if (rvalid && rready)
      cmp_bus({rresp, rdata}, rd_q.pop_front());
    if (bvalid && bready)
      cmp_bus({bresp, 32'h0}, {wr_q.pop_front(), 32'h0});
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // ==========================================
  // Bus master tasks; handshakes seen mid-cycle equal those at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    logic pa, pw, pb, sa, sw, sb;
    wr_q.push_back(r);
    @(posedge clock);
    {pa, pw, pb} = 3'b111;
    awaddr <= a;
    wdata <= ($urandom() << 8) | {24'h0, d};  // Upper bits ignored, so random
    {awvalid, wvalid, bready} <= 3'b111;
    while (pb) begin
      @(negedge clock);
      {sa, sw, sb} = {awready, wready, bvalid};
      @(posedge clock);
      // Task flags move at once, bus signals after the edge
      if (pa && sa) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && sw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (sb) begin
        bready <= 1'b0;
        pb = 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    logic sa, sr;
    rd_q.push_back({r, 24'h0, d});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    sr = 1'b0;
    while (!sr) begin
      @(negedge clock);
      {sa, sr} = {arready, rvalid};
      @(posedge clock);
      if (sa) arvalid <= 1'b0;
      if (sr) rready <= 1'b0;
    end
  endtask
  task automatic wait_run();
    while (cpu_reset !== 1'b0) @(posedge clock);
  endtask
  // One-cycle internal event: 0 voltage, 1 watchdog, 2 clock deadlock
  task automatic hit(input int k);
    @(posedge clock);
    tv = 8'($urandom());
    new_trim <= tv;
    @(posedge clock);
    {volt_detect, wdt_overflow, sysclk_sel} <= 3'b100 >> k;
    @(posedge clock);
    {volt_detect, wdt_overflow, sysclk_sel} <= 3'b000;
    @(negedge clock);
    cmp_lvl(cpu_reset, 1'b1);
    wait_run();
    rd(`RSC_OFS_TRIM, tv);
  endtask
  task automatic pin_low(input int n);
    @(posedge clock);
    pin_go <= 1'b1;
    @(posedge clock);
    pin_go <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  // ==========================================
  // Main sequence; keys go in the default gear only
  initial begin
    void'($urandom(32'hc84b));
    {sys_rst, volt_detect, wdt_overflow, sysclk_sel, pin_go, bad_par} = 6'b100000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {err_count, n_compared, cyc} = 0;
    {awaddr, araddr, wdata} = 48'h0;
    osc_enable = 2'b11;
    clk_en = 1'b1;
    tv = 8'($urandom());
    new_trim = tv;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    wait_run();
    rd(`RSC_OFS_CAUSE, 8'h00);
    rd(`RSC_OFS_TRIM, tv);
    rd(`RSC_OFS_KEY, 8'h00);
    rd(8'h14, 8'h00, `RSC_RESP_SLVERR);
    wr(8'h14, 8'hff, `RSC_RESP_SLVERR);
    // Frozen block must ignore a watchdog event; cause read later proves it
    clk_en <= 1'b0;
    @(posedge clock);
    wdt_overflow <= 1'b1;
    @(posedge clock);
    {wdt_overflow, clk_en} <= 2'b01;
    @(negedge clock);
    cmp_lvl(cpu_reset, 1'b0);
    osc_enable <= 2'b01;
    cause = 8'h00;
    for (int k = 0; k < 3; k++) begin
      hit(k);
      cause[k] = 1'b1;
      rd(`RSC_OFS_CAUSE, cause);
    end
    wr(`RSC_OFS_KEY, `RSC_KEY_CLEAR);
    rd(`RSC_OFS_CAUSE, 8'h07);
    wr(`RSC_OFS_CAUSE, 8'h80);
    rd(`RSC_OFS_CAUSE, 8'h87);
    wr(`RSC_OFS_KEY, `RSC_KEY_CLEAR);
    rd(`RSC_OFS_CAUSE, 8'h00);
    bad_par <= 1'b1;
    hit(1);
    rd(`RSC_OFS_CAUSE, 8'h12);
    bad_par <= 1'b0;
    hit(2);
    // Pin mode swaps made with the pin high
    wr(`RSC_OFS_PORT1, 8'h03);
    wr(`RSC_OFS_PINCFG, 8'h01);
    wr(`RSC_OFS_KEY, `RSC_KEY_PIN);
    @(negedge clock);
    cmp_lvl(port_mode_q, 1'b0);
    wr(`RSC_OFS_PORT1, 8'h01);
    wr(`RSC_OFS_KEY, `RSC_KEY_PIN);
    @(negedge clock);
    cmp_lvl(port_mode_q, 1'b1);
    rd(`RSC_OFS_PINCFG, 8'h07);
    pin_low(1100);
    @(negedge clock);
    cmp_lvl(cpu_reset, 1'b0);
    repeat (200) @(posedge clock);
    wr(`RSC_OFS_PINCFG, 8'h00);
    wr(`RSC_OFS_KEY, `RSC_KEY_PIN);
    @(negedge clock);
    cmp_lvl(port_mode_q, 1'b0);
    pin_low(1100);
    @(negedge clock);
    cmp_lvl(cpu_reset, 1'b1);
    wait_run();
    rd(`RSC_OFS_CAUSE, 8'h00);
    rd(`RSC_OFS_PINCFG, 8'h04);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
